// ==== logic/pcxlo_params.svh ====
`ifndef PCXLO_PARAMS_SVH
`define PCXLO_PARAMS_SVH

// Register index of the crossover and line options register, and its byte address.
`define PCXLO_IDX_XOVER 27
`define PCXLO_ADDR_XOVER (`PCXLO_IDX_XOVER * 4)
// Basic control register (holds the reset arm bit) and chip reset control register (holds the port PHY reset bit).
`define PCXLO_ADDR_BASIC_CTRL 8'h00
`define PCXLO_ADDR_CHIP_RST 8'h80

// Field positions in the crossover and line options register.
`define PCXLO_BIT_SRC_SEL 15
`define PCXLO_BIT_AUTO_EN 14
`define PCXLO_BIT_MAN_STATE 13
`define PCXLO_BIT_HB_DIS 11
`define PCXLO_BIT_PLL_HOLD 10
`define PCXLO_BIT_POL_REV 4
`define PCXLO_XOVER_WMASK 16'hec00
`define PCXLO_XOVER_RESET 16'h0000

// Field positions in the basic control and chip reset control registers.
`define PCXLO_BIT_BASIC_RST 15
`define PCXLO_BIT_PORT_RST 1

// Bus responses.
`define PCXLO_RESP_OKAY 2'b00
`define PCXLO_RESP_SLVERR 2'b10

`endif

// ==== logic/pcxlo_pkg.sv ====
package pcxlo_pkg;

  typedef enum logic [2:0]
  {
    PCXLO_MODE_STRAIGHT = 3'b001,
    PCXLO_MODE_CROSS = 3'b010,
    PCXLO_MODE_AUTO = 3'b100
  } pcxlo_mode_t;

endpackage

// ==== logic/pcxlo_xover_decode.sv ====
`timescale 1ns/10ps

module pcxlo_xover_decode
  import pcxlo_pkg::*;
(
  input wire logic i_source_select, // 1: register bits govern crossover
  input wire logic i_auto_enable, // register auto enable bit
  input wire logic i_manual_state, // register manual state bit
  input wire logic i_strap_auto, // auto crossover strap
  input wire logic i_strap_manual, // manual crossover strap
  output pcxlo_mode_t o_mode // resulting crossover mode
);

  // The reserved code 11 is mapped to straight so the line never floats in an undefined mode.
  function automatic pcxlo_mode_t pcxlo_bits_to_mode(input logic auto_en, input logic man_state);
    pcxlo_mode_t m;
    m = PCXLO_MODE_STRAIGHT;
    unique case ({auto_en, man_state})
      2'b00: m = PCXLO_MODE_STRAIGHT;
      2'b01: m = PCXLO_MODE_CROSS;
      2'b10: m = PCXLO_MODE_AUTO;
      2'b11: m = PCXLO_MODE_STRAIGHT;
    endcase
    return m;
  endfunction

  wire pcxlo_mode_t reg_mode;
  wire pcxlo_mode_t strap_mode;

  assign reg_mode = pcxlo_bits_to_mode(i_auto_enable, i_manual_state);
  assign strap_mode = pcxlo_bits_to_mode(i_strap_auto, i_strap_manual & ~i_strap_auto);
  assign o_mode = i_source_select ? reg_mode : strap_mode;

endmodule // pcxlo_xover_decode

// ==== logic/pcxlo_top.sv ====
// Overview of operation
// - One 16-bit register at index 27.
// - Bit 15 set: register bits override straps.
// - Bit 15 clear (reset): straps govern crossover.
// - Bits 14:13 select straight, crossover, auto.
// - Bit 11 set disables heartbeat test.
// - Bit 10 holds 10M receive PLL on reference.
// - Read-only bit 4 shows reversed polarity.
// - Port PHY reset clears control bits if armed.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "pcxlo_params.svh"

module pcxlo_top
  import pcxlo_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic i_sys_clk, // 40 MHz system clock
  input wire logic i_resetn, // synchronous reset, active low
  input wire logic [ADDR_W-1:0] i_axi_awaddr, // write address
  input wire logic i_axi_awvalid, // write address valid
  output logic o_axi_awready, // write address ready
  input wire logic [31:0] i_axi_wdata, // write data
  input wire logic [3:0] i_axi_wstrb, // write byte strobes
  input wire logic i_axi_wvalid, // write data valid
  output logic o_axi_wready, // write data ready
  output logic [1:0] o_axi_bresp, // write response
  output logic o_axi_bvalid, // write response valid
  input wire logic i_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] i_axi_araddr, // read address
  input wire logic i_axi_arvalid, // read address valid
  output logic o_axi_arready, // read address ready
  output logic [31:0] o_axi_rdata, // read data
  output logic [1:0] o_axi_rresp, // read response
  output logic o_axi_rvalid, // read data valid
  input wire logic i_axi_rready, // read data ready
  input wire logic i_strap_auto, // auto crossover strap level
  input wire logic i_strap_manual, // manual crossover strap level
  input wire logic i_polarity_reversed, // 10BASE-T receive polarity from the line
  output logic o_crossover_auto_enable, // automatic crossover detection active
  output logic o_crossover_cross, // manual crossover applied
  output logic o_heartbeat_test_disable, // heartbeat test off
  output logic o_rx_pll_reference_hold, // 10M receive PLL held on reference
  output logic o_port_phy_reset // one-cycle port PHY reset pulse
);

  ////////////////////////////////////////////////////////////////////////////////////////////////

  function automatic logic pcxlo_addr_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] target);
    return addr[ADDR_W-1:2] == target[ADDR_W-1:2];
  endfunction

  localparam logic [ADDR_W-1:0] ADDR_XOVER = ADDR_W'(`PCXLO_ADDR_XOVER);
  localparam logic [ADDR_W-1:0] ADDR_BASIC = ADDR_W'(`PCXLO_ADDR_BASIC_CTRL);
  localparam logic [ADDR_W-1:0] ADDR_CHIP = ADDR_W'(`PCXLO_ADDR_CHIP_RST);

  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] araddr_q;
  logic ar_held_q;
  logic awready_q;
  logic wready_q;
  logic arready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  logic [15:0] xover_q;
  logic pol_q;
  logic basic_rst_q;
  logic port_rst_q;
  logic auto_q;
  logic cross_q;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Write channel handshakes; address and data may arrive in either order.

  wire aw_hs = i_axi_awvalid & awready_q;
  wire w_hs = i_axi_wvalid & wready_q;
  wire do_write = aw_held_q & w_held_q & ~bvalid_q;
  wire aw_held_d = (aw_held_q & ~do_write) | aw_hs;
  wire w_held_d = (w_held_q & ~do_write) | w_hs;
  wire b_done = bvalid_q & i_axi_bready;

  wire wr_xover = do_write & pcxlo_addr_hit(awaddr_q, ADDR_XOVER);
  wire wr_basic = do_write & pcxlo_addr_hit(awaddr_q, ADDR_BASIC);
  wire wr_chip = do_write & pcxlo_addr_hit(awaddr_q, ADDR_CHIP);
  wire wr_mapped = wr_xover | wr_basic | wr_chip;

  // Only the high byte holds writable bits, so lane 1 gates crossover and basic control writes; the port reset request is gated by lane 0.
  wire [15:0] xover_wmask = `PCXLO_XOVER_WMASK;
  // The merge uses the held data word, since the data channel may have moved on by the time the write lands.
  wire [15:0] xover_wr_val = (xover_q & ~xover_wmask) | (wdata_q[15:0] & xover_wmask);
  wire xover_we = wr_xover & wstrb_q[1];

  // A chip-level port reset clears the control bits only while the basic reset bit is armed.
  wire port_rst_req = wr_chip & wstrb_q[0] & wdata_q[`PCXLO_BIT_PORT_RST];
  wire ctrl_clear = port_rst_req & basic_rst_q;
  wire basic_we = wr_basic & wstrb_q[1];

  wire [15:0] xover_d = ctrl_clear ? `PCXLO_XOVER_RESET : (xover_we ? xover_wr_val : xover_q);

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `PCXLO_RESP_OKAY;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awready_q <= ~aw_held_d;
      wready_q <= ~w_held_d;
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? `PCXLO_RESP_OKAY : `PCXLO_RESP_SLVERR;
      end
      else if (b_done)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (aw_hs)
    begin
      awaddr_q <= i_axi_awaddr;
    end
    if (w_hs)
    begin
      wdata_q <= i_axi_wdata;
      wstrb_q <= i_axi_wstrb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Read channel: one read outstanding, answered the cycle after the address is held.

  wire ar_hs = i_axi_arvalid & arready_q;
  wire do_read = ar_held_q & ~rvalid_q;
  wire ar_held_d = (ar_held_q & ~do_read) | ar_hs;
  wire rd_xover = pcxlo_addr_hit(araddr_q, ADDR_XOVER);
  wire rd_basic = pcxlo_addr_hit(araddr_q, ADDR_BASIC);
  wire rd_chip = pcxlo_addr_hit(araddr_q, ADDR_CHIP);

  wire [15:0] xover_rd_val = (xover_q & xover_wmask) | (16'(pol_q) << `PCXLO_BIT_POL_REV);
  wire [15:0] basic_rd_val = 16'(basic_rst_q) << `PCXLO_BIT_BASIC_RST;
  // The port reset request is write-only and always reads back as zero.
  wire [31:0] rd_val = rd_xover ? {16'h0000, xover_rd_val} : (rd_basic ? {16'h0000, basic_rd_val} : 32'h0000_0000);
  wire rd_mapped = rd_xover | rd_basic | rd_chip;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      ar_held_q <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= `PCXLO_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ar_held_q <= ar_held_d;
      arready_q <= ~ar_held_d;
      if (do_read)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_val;
        rresp_q <= rd_mapped ? `PCXLO_RESP_OKAY : `PCXLO_RESP_SLVERR;
      end
      else if (rvalid_q & i_axi_rready)
      begin
        rvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (ar_hs)
    begin
      araddr_q <= i_axi_araddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Control state and the line-facing outputs.

  wire pcxlo_mode_t mode;

  pcxlo_xover_decode u_decode
  (
    .i_source_select (xover_q[`PCXLO_BIT_SRC_SEL]),
    .i_auto_enable (xover_q[`PCXLO_BIT_AUTO_EN]),
    .i_manual_state (xover_q[`PCXLO_BIT_MAN_STATE]),
    .i_strap_auto (i_strap_auto),
    .i_strap_manual (i_strap_manual),
    .o_mode (mode)
  );

  // The reset bit is self-clearing: it drops once the armed port reset has been issued.
  // Software may also disarm it by writing zero; a write and a port reset never land in one cycle.
  wire basic_rst_d = basic_we ? wdata_q[`PCXLO_BIT_BASIC_RST] : (basic_rst_q & ~ctrl_clear);

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      xover_q <= `PCXLO_XOVER_RESET;
      pol_q <= 1'b0;
      basic_rst_q <= 1'b0;
      port_rst_q <= 1'b0;
      auto_q <= 1'b0;
      cross_q <= 1'b0;
    end
    else
    begin
      xover_q <= xover_d;
      pol_q <= i_polarity_reversed;
      basic_rst_q <= basic_rst_d;
      port_rst_q <= port_rst_req;
      auto_q <= mode == PCXLO_MODE_AUTO;
      cross_q <= mode == PCXLO_MODE_CROSS;
    end
  end

  assign o_axi_awready = awready_q;
  assign o_axi_wready = wready_q;
  assign o_axi_bvalid = bvalid_q;
  assign o_axi_bresp = bresp_q;
  assign o_axi_arready = arready_q;
  assign o_axi_rvalid = rvalid_q;
  assign o_axi_rresp = rresp_q;
  assign o_axi_rdata = rdata_q;
  assign o_crossover_auto_enable = auto_q;
  assign o_crossover_cross = cross_q;
  assign o_heartbeat_test_disable = xover_q[`PCXLO_BIT_HB_DIS];
  assign o_rx_pll_reference_hold = xover_q[`PCXLO_BIT_PLL_HOLD];
  assign o_port_phy_reset = port_rst_q;

endmodule // pcxlo_top

// ==== sim/pcxlo_top_properties.sv ====
`timescale 1ns/10ps
`include "pcxlo_params.svh"

module pcxlo_top_properties
#(
  parameter int ADDR_W = 8
)
(
  input wire logic i_sys_clk, // clock
  input wire logic i_resetn, // reset
  input wire logic [ADDR_W-1:0] i_axi_araddr, // rd addr
  input wire logic i_axi_arvalid, // ar valid
  input wire logic o_axi_arready, // ar ready
  input wire logic [31:0] o_axi_rdata, // rd data
  input wire logic [1:0] o_axi_rresp, // rd resp
  input wire logic o_axi_rvalid, // r valid
  input wire logic i_axi_rready, // r ready
  input wire logic i_axi_awvalid, // aw valid
  input wire logic o_axi_awready, // aw ready
  input wire logic i_axi_wvalid, // w valid
  input wire logic o_axi_wready, // w ready
  input wire logic o_axi_bvalid, // b valid
  input wire logic i_axi_bready, // b ready
  input wire logic o_crossover_auto_enable, // auto
  input wire logic o_crossover_cross, // cross
  input wire logic o_heartbeat_test_disable, // heartbeat test off
  input wire logic o_rx_pll_reference_hold, // pll held
  input wire logic o_port_phy_reset // reset pulse
);
  logic rd_x_q;
  logic rd_bad_q;
  logic [7:0] ra;

  ////////////////////////////////////////////////////////////////////////
  // The read address is kept so that the answer can be judged by target.
  assign ra = {i_axi_araddr[7:2], 2'h0};
  always_ff @(posedge i_sys_clk)
  begin
    if (i_axi_arvalid && o_axi_arready)
    begin
      rd_x_q <= ra == 8'(`PCXLO_ADDR_XOVER);
      rd_bad_q <= ra != 8'(`PCXLO_ADDR_XOVER) && ra != `PCXLO_ADDR_BASIC_CTRL && ra != `PCXLO_ADDR_CHIP_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  AST_AR_TAKE: assert property (i_axi_arvalid && o_axi_arready |=> !o_axi_arready ##1 o_axi_rvalid)
    else $error("read answer late");
  AST_R_DONE: assert property (o_axi_rvalid && i_axi_rready |=> !o_axi_rvalid && o_axi_arready)
    else $error("read not closed");
  AST_W_TAKE: assert property (i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready |=>
    !o_axi_awready && !o_axi_wready ##1 o_axi_bvalid)
    else $error("write answer late");
  AST_B_DONE: assert property (o_axi_bvalid && i_axi_bready
    |=> !o_axi_bvalid && o_axi_awready && o_axi_wready)
    else $error("write not closed");
  AST_RSV_ZERO: assert property (o_axi_rvalid && rd_x_q |-> (o_axi_rdata & 32'hffff13ef) == 32'h0)
    else $error("reserved bits set");
  AST_UNMAPPED: assert property (o_axi_rvalid && rd_bad_q |-> o_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  AST_MODE_ONE: assert property (!(o_crossover_auto_enable && o_crossover_cross))
    else $error("two modes at once");
  AST_PRST_PULSE: assert property ($rose(o_port_phy_reset) |=> !o_port_phy_reset)
    else $error("port reset too long");
  // The read word is captured one edge before it shows, so it must match the line outputs of that edge.
  AST_RD_LINE: assert property ($rose(o_axi_rvalid) && rd_x_q
    |-> o_axi_rdata[11] == $past(o_heartbeat_test_disable) && o_axi_rdata[10] == $past(o_rx_pll_reference_hold))
    else $error("line outputs differ from read back");

  cover property (o_axi_rvalid && rd_x_q);
  cover property (o_port_phy_reset);
  cover property (o_crossover_auto_enable);
endmodule // pcxlo_top_properties

bind pcxlo_top pcxlo_top_properties #(.ADDR_W(ADDR_W)) u_pcxlo_top_properties
(
  .i_sys_clk, .i_resetn, .i_axi_araddr, .i_axi_arvalid, .o_axi_arready, .o_axi_rdata, .o_axi_rresp,
  .o_axi_rvalid, .i_axi_rready, .i_axi_awvalid, .o_axi_awready, .i_axi_wvalid, .o_axi_wready,
  .o_axi_bvalid, .i_axi_bready, .o_crossover_auto_enable, .o_crossover_cross, .o_heartbeat_test_disable,
  .o_rx_pll_reference_hold, .o_port_phy_reset
);

// ==== sim/pcxlo_top_tb.sv ====
`timescale 1ns/10ps
`include "pcxlo_params.svh"

module pcxlo_top_tb;
  `define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin failures++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
  localparam logic [7:0] AX = 8'(`PCXLO_ADDR_XOVER);
  logic i_sys_clk, i_resetn, i_axi_awvalid, i_axi_wvalid, i_axi_bready, i_axi_arvalid, i_axi_rready;
  logic i_strap_auto, i_strap_manual, i_polarity_reversed;
  logic [7:0] i_axi_awaddr, i_axi_araddr;
  logic [31:0] i_axi_wdata, o_axi_rdata, rd_d;
  logic [3:0] i_axi_wstrb;
  logic [1:0] o_axi_bresp, o_axi_rresp, resp;
  logic o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
  logic o_crossover_auto_enable, o_crossover_cross, o_heartbeat_test_disable;
  logic o_rx_pll_reference_hold, o_port_phy_reset;
  logic [15:0] xr;
  int failures, n_compared, n_pulse;

  pcxlo_top u_pcxlo_top
  (
    .i_sys_clk, .i_resetn, .i_axi_awaddr, .i_axi_awvalid, .o_axi_awready, .i_axi_wdata, .i_axi_wstrb,
    .i_axi_wvalid, .o_axi_wready, .o_axi_bresp, .o_axi_bvalid, .i_axi_bready, .i_axi_araddr,
    .i_axi_arvalid, .o_axi_arready, .o_axi_rdata, .o_axi_rresp, .o_axi_rvalid, .i_axi_rready,
    .i_strap_auto, .i_strap_manual, .i_polarity_reversed, .o_crossover_auto_enable, .o_crossover_cross,
    .o_heartbeat_test_disable, .o_rx_pll_reference_hold, .o_port_phy_reset
  );

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk)
    if (o_port_phy_reset === 1'b1) n_pulse++;

  // Returns {auto, cross}; the auto strap outranks the manual strap.
  function automatic logic [1:0] exp_mode(input logic [15:0] r, input logic sa, input logic sm);
    if (r[15]) return {r[14] & ~r[13], ~r[14] & r[13]};
    return {sa, ~sa & sm};
  endfunction

  // The wr and rd tasks first let an edge pass so no handshake signal is driven twice in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge i_sys_clk);
    i_axi_awaddr <= a;
    i_axi_wdata <= d;
    i_axi_wstrb <= s;
    {i_axi_awvalid, i_axi_wvalid, i_axi_bready} <= 3'h7;
    do
    begin
      @(posedge i_sys_clk);
      if (o_axi_awready) i_axi_awvalid <= 1'b0;
      if (o_axi_wready) i_axi_wvalid <= 1'b0;
    end while (o_axi_bvalid !== 1'b1);
    resp = o_axi_bresp;
    i_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_axi_araddr <= a;
    {i_axi_arvalid, i_axi_rready} <= 2'h3;
    do
    begin
      @(posedge i_sys_clk);
      if (o_axi_arready) i_axi_arvalid <= 1'b0;
    end while (o_axi_rvalid !== 1'b1);
    rd_d = o_axi_rdata;
    resp = o_axi_rresp;
    i_axi_rready <= 1'b0;
  endtask

  task automatic check_reg();
    rd(AX);
    `CHK("rresp", 2'h0, resp)
    `CHK("xover", {16'h0, xr[15:5], i_polarity_reversed, xr[3:0]}, rd_d)
    `CHK("mode", exp_mode(xr, i_strap_auto, i_strap_manual), {o_crossover_auto_enable, o_crossover_cross})
    `CHK("line", xr[11:10], {o_heartbeat_test_disable, o_rx_pll_reference_hold})
  endtask

  task automatic test_done();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6000) @(posedge i_sys_clk);
    failures++;
    test_done();
  end

  initial
  begin
    {i_resetn, i_axi_awvalid, i_axi_wvalid, i_axi_bready, i_axi_arvalid, i_axi_rready} = '0;
    {i_strap_auto, i_strap_manual, i_polarity_reversed, i_axi_awaddr, i_axi_araddr} = '0;
    {i_axi_wdata, i_axi_wstrb} = '0;
    void'($urandom(32'h30058f15));
    repeat (8) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    xr = 16'h0;
    check_reg();
    wr(8'h44, 32'hffff, 4'hf);
    `CHK("bresp", 2'h2, resp)
    rd(8'h44);
    `CHK("rresp bad", 2'h2, resp)
    for (int i = 0; i < 24; i++)
    begin
      logic [15:0] d;
      logic [3:0] s;
      d = 16'($urandom());
      if (i < 3) d[15:13] = {1'b1, 2'(i)};
      else if (d[14:13] == 2'h3) d[13] = 1'b0;
      s = (i % 5 == 4) ? 4'hd : 4'hf;
      {i_strap_auto, i_strap_manual, i_polarity_reversed} <= 3'($urandom());
      wr(AX, {16'h0, d}, s);
      if (s[1]) xr = d & 16'hec00;
      check_reg();
    end
    wr(AX, 32'hcc00, 4'hf);
    `CHK("bresp ok", 2'h0, resp)
    xr = 16'hcc00;
    wr(8'(`PCXLO_ADDR_CHIP_RST), 32'h2, 4'h1);
    check_reg();
    wr(`PCXLO_ADDR_BASIC_CTRL, 32'h8000, 4'hf);
    rd(`PCXLO_ADDR_BASIC_CTRL);
    `CHK("arm", 32'h8000, rd_d)
    wr(8'(`PCXLO_ADDR_CHIP_RST), 32'h2, 4'h1);
    xr = 16'h0;
    check_reg();
    rd(`PCXLO_ADDR_BASIC_CTRL);
    `CHK("arm cleared", 32'h0, rd_d)
    `CHK("pulses", 2, n_pulse)
    test_done();
  end
endmodule // pcxlo_top_tb
